//--- inc/pllodn_regs.vh
// register map, field layout, reset values and divide ratios of the output divider network
`ifndef PLLODN_REGS_VH
`define PLLODN_REGS_VH

// byte offsets on the AHB-Lite bus
`define PLLODN_ADDR_CTRL 8'h00
`define PLLODN_ADDR_STAT 8'h04

// control register fields
`define PLLODN_CTRL_BUS_LO 0
`define PLLODN_CTRL_BUS_HI 1
`define PLLODN_CTRL_PER_LO 2
`define PLLODN_CTRL_PER_HI 3
`define PLLODN_CTRL_BYPASS 4
`define PLLODN_CTRL_LEGACY 5
`define PLLODN_CTRL_FBSEL 6
`define PLLODN_CTRL_WIDTH 7
// all inputs pulled high by default
`define PLLODN_CTRL_RESET 7'h7f

// status register fields
`define PLLODN_STAT_DOUBLE 0
`define PLLODN_STAT_HALF 1
`define PLLODN_STAT_QUAL 2
`define PLLODN_STAT_BUS 3
`define PLLODN_STAT_PER 4
`define PLLODN_STAT_FBINT 5
`define PLLODN_STAT_DRIVING 6
`define PLLODN_STAT_PHASE 7

// divide ratios in prescaler ticks (vco cycles when bypassed); feedback ratio in vco cycles
`define PLLODN_DIV_DOUBLE_LEGACY 6'h02
`define PLLODN_DIV_QUARTER 6'h04
`define PLLODN_DIV_BUS_00 6'h04
`define PLLODN_DIV_BUS_01 6'h08
`define PLLODN_DIV_BUS_10 6'h0c
`define PLLODN_DIV_BUS_11 6'h10
`define PLLODN_DIV_FEEDBACK 6'h20

// qualifier high time for the divide-by-three and divide-by-four cases
`define PLLODN_QUAL_HIGH_12 6'h08
`define PLLODN_QUAL_HIGH_16 6'h0c

// timing
`define PLLODN_CLK_PERIOD_PS 20000
`define PLLODN_QUAL_LAG_PS 100

`endif

//--- rtl/pllodn_divider_network.v
// output divider network of a pll clock driver with an AHB-Lite control slave
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pllodn_regs.vh"

module pllodn_divider_network #(
	parameter BUS_COUNT = 5,
	parameter PER_COUNT = 7
) (
	// clock and reset; clock_in stands for the vco
	input wire clock_in,
	input wire srst_in,
	input wire master_reset_hiz_n_in,
	// AHB-Lite slave
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output reg [31:0] hrdata_out,
	output reg hreadyout_out,
	output reg hresp_out,
	// feedback path
	input wire external_feedback_in,
	output reg phase_detector_feedback_out,
	// clock outputs, enables low while driven
	output reg double_rate_cpu_clock_out,
	output reg double_rate_cpu_clock_oe_n_out,
	output reg half_rate_cpu_clock_out,
	output reg half_rate_cpu_clock_oe_n_out,
	output reg bus_clock_qualifier_out,
	output reg bus_clock_qualifier_oe_n_out,
	output reg [BUS_COUNT-1:0] bus_clock_out,
	output reg [BUS_COUNT-1:0] bus_clock_oe_n_out,
	output reg [PER_COUNT-1:0] peripheral_bus_clock_out,
	output reg [PER_COUNT-1:0] peripheral_bus_clock_oe_n_out
);

	// hold lag rounded up to whole vco cycles, never below one
	localparam QUAL_LAG_RAW = (`PLLODN_QUAL_LAG_PS + `PLLODN_CLK_PERIOD_PS - 1) / `PLLODN_CLK_PERIOD_PS;
	localparam QUAL_LAG_CYC = (QUAL_LAG_RAW < 1) ? 1 : QUAL_LAG_RAW;

	wire core_reset;
	reg [`PLLODN_CTRL_WIDTH-1:0] ctrl;
	reg addr_phase_write;
	reg addr_phase_ctrl;
	reg prescale_phase;
	reg [5:0] double_count;
	reg [5:0] half_count;
	reg [5:0] bus_count;
	reg [5:0] per_count;
	reg [5:0] fb_count;
	reg [QUAL_LAG_CYC-1:0] qual_lag;
	reg [5:0] bus_ratio;
	reg [5:0] per_ratio;
	reg [5:0] double_ratio;
	reg [5:0] qual_ratio;
	reg [5:0] qual_high;
	reg [5:0] qual_count_sel;
	reg next_double;
	reg next_half;
	reg next_qual;
	reg next_bus;
	reg next_per;
	reg next_fb_int;
	reg fb_int;
	reg [31:0] next_rdata;
	wire [1:0] bus_ratio_select;
	wire [1:0] peripheral_ratio_select;
	wire prescaler_bypass;
	wire legacy_cpu_mode;
	wire feedback_source_select;
	wire tick;
	wire take;
	wire addr_in_map;
	wire restart;

	// master reset pin also clears the core
	assign core_reset = srst_in | ~master_reset_hiz_n_in;

	assign bus_ratio_select = ctrl[`PLLODN_CTRL_BUS_HI:`PLLODN_CTRL_BUS_LO];
	assign peripheral_ratio_select = ctrl[`PLLODN_CTRL_PER_HI:`PLLODN_CTRL_PER_LO];
	assign prescaler_bypass = ctrl[`PLLODN_CTRL_BYPASS];
	assign legacy_cpu_mode = ctrl[`PLLODN_CTRL_LEGACY];
	assign feedback_source_select = ctrl[`PLLODN_CTRL_FBSEL];

	// writes and reads decode the same address window
	assign addr_in_map = haddr_in[31:8] == 24'h00_0000;
	assign take = hsel_in & htrans_in[1] & hready_in;

	// a ratio write restarts the cpu, bus and peripheral dividers so related edges stay aligned
	assign restart = core_reset | (addr_phase_write & addr_phase_ctrl);

	// bus slave: zero wait states, always okay
	always @(posedge clock_in)
	begin
		if (srst_in)
		begin
			addr_phase_write <= 1'b0;
			addr_phase_ctrl <= 1'b0;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
		else
		begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			// address phase captured only while the bus is ready
			if (hready_in)
			begin
				addr_phase_write <= take & hwrite_in;
				addr_phase_ctrl <= addr_in_map & (haddr_in[7:0] == `PLLODN_ADDR_CTRL);
				hrdata_out <= (take & ~hwrite_in) ? next_rdata : 32'h0000_0000;
			end
		end
	end

	// read mux; unmapped offsets read zero
	always @*
	begin
		next_rdata = 32'h0000_0000;
		if (addr_in_map)
		begin
			case (haddr_in[7:0])
				`PLLODN_ADDR_CTRL:
					next_rdata = {25'h000_0000, ctrl};
				// status shows the registered clock outputs, the internal feedback divider, the drive state and the prescaler phase
				`PLLODN_ADDR_STAT:
					next_rdata = {24'h00_0000, prescale_phase, ~double_rate_cpu_clock_oe_n_out, fb_int,
						peripheral_bus_clock_out[0], bus_clock_out[0], bus_clock_qualifier_out,
						half_rate_cpu_clock_out, double_rate_cpu_clock_out};
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// control register; reset models the pull-ups
	always @(posedge clock_in)
	begin
		if (srst_in)
			ctrl <= `PLLODN_CTRL_RESET;
		else if (addr_phase_write & addr_phase_ctrl)
			ctrl <= hwdata_in[`PLLODN_CTRL_WIDTH-1:0];
	end

	// prescaler: every vco edge when bypassed, every second otherwise
	always @(posedge clock_in)
	begin
		if (core_reset)
			prescale_phase <= 1'b0;
		else
			prescale_phase <= ~prescale_phase;
	end
	assign tick = prescaler_bypass | prescale_phase;

	// ratio selection
	always @*
	begin
		case (bus_ratio_select)
			2'b00: bus_ratio = `PLLODN_DIV_BUS_00;
			2'b01: bus_ratio = `PLLODN_DIV_BUS_01;
			2'b10: bus_ratio = `PLLODN_DIV_BUS_10;
			default: bus_ratio = `PLLODN_DIV_BUS_11;
		endcase
		// bus/3 is bus plus twice bus, no multiplier needed
		case (peripheral_ratio_select)
			2'b00: per_ratio = bus_ratio;
			2'b01: per_ratio = {bus_ratio[4:0], 1'b0};
			2'b10: per_ratio = bus_ratio + {bus_ratio[4:0], 1'b0};
			default: per_ratio = `PLLODN_DIV_QUARTER;
		endcase
		double_ratio = legacy_cpu_mode ? `PLLODN_DIV_DOUBLE_LEGACY : `PLLODN_DIV_QUARTER;
		qual_ratio = legacy_cpu_mode ? bus_ratio : `PLLODN_DIV_QUARTER;
		// uneven high times for the /3 and /4 qualifier cases
		case (bus_ratio_select)
			2'b10: qual_high = `PLLODN_QUAL_HIGH_12;
			2'b11: qual_high = `PLLODN_QUAL_HIGH_16;
			default: qual_high = {1'b0, bus_ratio[5:1]};
		endcase
		if (!legacy_cpu_mode)
			qual_high = {1'b0, qual_ratio[5:1]};
	end

	// cpu, bus and peripheral dividers cleared together and advanced on the same tick
	// a counter past a shrunken ratio would wrap out of step, hence the restart
	always @(posedge clock_in)
	begin
		if (restart)
		begin
			double_count <= 6'h00;
			half_count <= 6'h00;
			bus_count <= 6'h00;
			per_count <= 6'h00;
		end
		else if (tick)
		begin
			double_count <= (double_count >= double_ratio - 6'h01) ? 6'h00 : double_count + 6'h01;
			half_count <= (half_count >= `PLLODN_DIV_QUARTER - 6'h01) ? 6'h00 : half_count + 6'h01;
			bus_count <= (bus_count >= bus_ratio - 6'h01) ? 6'h00 : bus_count + 6'h01;
			per_count <= (per_count >= per_ratio - 6'h01) ? 6'h00 : per_count + 6'h01;
		end
	end

	// feedback divider runs on every vco edge, ahead of the prescaler
	always @(posedge clock_in)
	begin
		if (core_reset)
			fb_count <= 6'h00;
		else
			fb_count <= (fb_count >= `PLLODN_DIV_FEEDBACK - 6'h01) ? 6'h00 : fb_count + 6'h01;
	end

	// output levels: high for the first part of each period
	always @*
	begin
		qual_count_sel = legacy_cpu_mode ? bus_count : half_count;
		next_double = double_count < {1'b0, double_ratio[5:1]};
		next_half = half_count < {1'b0, `PLLODN_DIV_QUARTER >> 1};
		next_qual = qual_count_sel < qual_high;
		next_bus = bus_count < {1'b0, bus_ratio[5:1]};
		next_per = per_count < {1'b0, per_ratio[5:1]};
		next_fb_int = fb_count < {1'b0, `PLLODN_DIV_FEEDBACK >> 1};
	end

	// qualifier lag line for legacy mode; one stage needs no shift
	generate
		if (QUAL_LAG_CYC == 1)
		begin : g_lag_one
			always @(posedge clock_in)
			begin
				if (core_reset)
					qual_lag <= 1'b0;
				else
					qual_lag <= next_qual;
			end
		end
		else
		begin : g_lag_many
			always @(posedge clock_in)
			begin
				if (core_reset)
					qual_lag <= {QUAL_LAG_CYC{1'b0}};
				else
					qual_lag <= {qual_lag[QUAL_LAG_CYC-2:0], next_qual};
			end
		end
	endgenerate

	// single outputs and feedback selection
	always @(posedge clock_in)
	begin
		if (core_reset)
		begin
			double_rate_cpu_clock_out <= 1'b0;
			double_rate_cpu_clock_oe_n_out <= 1'b1;
			half_rate_cpu_clock_out <= 1'b0;
			half_rate_cpu_clock_oe_n_out <= 1'b1;
			bus_clock_qualifier_out <= 1'b0;
			bus_clock_qualifier_oe_n_out <= 1'b1;
			fb_int <= 1'b0;
			phase_detector_feedback_out <= 1'b0;
		end
		else
		begin
			double_rate_cpu_clock_out <= next_double;
			double_rate_cpu_clock_oe_n_out <= 1'b0;
			half_rate_cpu_clock_out <= next_half;
			half_rate_cpu_clock_oe_n_out <= 1'b0;
			bus_clock_qualifier_out <= legacy_cpu_mode ? qual_lag[QUAL_LAG_CYC-1] : next_qual;
			bus_clock_qualifier_oe_n_out <= 1'b0;
			fb_int <= next_fb_int;
			// external feedback passes one flop, like the internal path
			phase_detector_feedback_out <= feedback_source_select ? next_fb_int : external_feedback_in;
		end
	end

	// fan-out copies of the bus and peripheral clocks
	// each copy has its own flop so one load cannot disturb another
	genvar i;
	generate
		for (i = 0; i < BUS_COUNT; i = i + 1)
		begin : g_bus
			always @(posedge clock_in)
			begin
				if (core_reset)
				begin
					bus_clock_out[i] <= 1'b0;
					bus_clock_oe_n_out[i] <= 1'b1;
				end
				else
				begin
					bus_clock_out[i] <= next_bus;
					bus_clock_oe_n_out[i] <= 1'b0;
				end
			end
		end
		for (i = 0; i < PER_COUNT; i = i + 1)
		begin : g_per
			always @(posedge clock_in)
			begin
				if (core_reset)
				begin
					peripheral_bus_clock_out[i] <= 1'b0;
					peripheral_bus_clock_oe_n_out[i] <= 1'b1;
				end
				else
				begin
					peripheral_bus_clock_out[i] <= next_per;
					peripheral_bus_clock_oe_n_out[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

//--- bench/pllodn_chk.sv
// port checks for the output divider network
`timescale 1ns/1ps
module pllodn_chk #(
	parameter BUS_COUNT = 5,
	parameter PER_COUNT = 7
) (
	// clock, resets and bus writes
	input wire clock_in,
	input wire srst_in,
	input wire master_reset_hiz_n_in,
	input wire hsel_in,
	input wire hwrite_in,
	// clock outputs
	input wire double_rate_cpu_clock_out,
	input wire half_rate_cpu_clock_out,
	input wire half_rate_cpu_clock_oe_n_out,
	input wire bus_clock_qualifier_out,
	input wire [BUS_COUNT-1:0] bus_clock_out,
	input wire [PER_COUNT-1:0] peripheral_bus_clock_out,
	input wire [PER_COUNT-1:0] peripheral_bus_clock_oe_n_out
);
	reg d1 = 1'b0;
	reg d2 = 1'b0;
	reg [7:0] calm = 8'h00;
	wire settled = calm > 8'hc8;
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (srst_in);
	// a ratio write may cut one period short
	always @(posedge clock_in)
	begin
		d1 <= double_rate_cpu_clock_out;
		d2 <= d1;
		calm <= (srst_in || (hsel_in && hwrite_in)) ? 8'h00 : calm + {7'h00, calm != 8'hff};
	end
	a_hiz_float: assert property (
		!master_reset_hiz_n_in |=> &peripheral_bus_clock_oe_n_out && !bus_clock_out[0])
		else $error("outputs not floated in master reset");
	a_drive_on: assert property (
		master_reset_hiz_n_in |=> !half_rate_cpu_clock_oe_n_out && peripheral_bus_clock_oe_n_out == '0)
		else $error("outputs not driven");
	a_bus_copies: assert property (
		bus_clock_out == {BUS_COUNT{bus_clock_out[0]}})
		else $error("bus clock copies differ");
	a_per_copies: assert property (
		peripheral_bus_clock_out == {PER_COUNT{peripheral_bus_clock_out[0]}})
		else $error("peripheral clock copies differ");
	a_half_double: assert property (
		settled && $rose(half_rate_cpu_clock_out) |-> $rose(double_rate_cpu_clock_out))
		else $error("half clock rise without double clock rise");
	a_bus_half: assert property (
		settled && $rose(bus_clock_out[0]) |-> $rose(half_rate_cpu_clock_out))
		else $error("bus clock rise misaligned");
	a_per_half: assert property (
		settled && $rose(peripheral_bus_clock_out[0]) |-> $rose(half_rate_cpu_clock_out))
		else $error("peripheral clock rise misaligned");
	a_qual_lag: assert property (
		settled && $rose(bus_clock_qualifier_out) |-> $rose(double_rate_cpu_clock_out) || (d1 && !d2))
		else $error("qualifier rise at wrong offset");
endmodule

//--- bench/pllodn_clock_load.sv
// clock load that times the period and high phase of one clock output
`timescale 1ns/1ps
module pllodn_clock_load (
	// sampling clock and observed clock
	input wire clock_in,
	input wire tap_in,
	// last full period and high time in clock_in cycles
	output logic [31:0] period_out,
	output logic [31:0] high_out
);
	logic [31:0] cnt = 32'h0000_0000;
	logic [31:0] hi = 32'h0000_0000;
	logic last = 1'b1;
	wire rise = tap_in === 1'b1 && last === 1'b0;
	always @(posedge clock_in)
	begin
		last <= tap_in;
		cnt <= rise ? 32'h0000_0001 : cnt + 32'h0000_0001;
		hi <= rise ? 32'h0000_0001 : hi + {31'h0000_0000, tap_in === 1'b1};
		if (rise)
		begin
			period_out <= cnt;
			high_out <= hi;
		end
	end
endmodule

//--- bench/tb.sv
// self-checking bench for the output divider network
`timescale 1ns/1ps
`include "pllodn_regs.vh"
module tb;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic master_reset_hiz_n_in = 1'b1;
	logic hsel_in = 1'b0;
	logic hwrite_in = 1'b0;
	logic [1:0] htrans_in = 2'h0;
	logic [2:0] hsize_in = 3'h2;
	logic [31:0] haddr_in = 32'h0000_0000;
	logic [31:0] hwdata_in = 32'h0000_0000;
	logic [31:0] rd;
	wire [31:0] hrdata_out;
	wire hreadyout_out, hresp_out, phase_detector_feedback_out, double_rate_cpu_clock_out;
	wire double_rate_cpu_clock_oe_n_out, half_rate_cpu_clock_out, half_rate_cpu_clock_oe_n_out;
	wire bus_clock_qualifier_out, bus_clock_qualifier_oe_n_out;
	wire [4:0] bus_clock_out, bus_clock_oe_n_out;
	wire [6:0] peripheral_bus_clock_out, peripheral_bus_clock_oe_n_out;
	wire [31:0] per_q [0:5];
	wire [31:0] hi_q [0:5];
	wire [5:0] taps = {phase_detector_feedback_out, peripheral_bus_clock_out[0], bus_clock_out[0],
		bus_clock_qualifier_out, half_rate_cpu_clock_out, double_rate_cpu_clock_out};
	int num_errors = 0;
	int cmp_count = 0;
	always #10 clock_in = ~clock_in;
	pllodn_divider_network u_dut (.clock_in, .srst_in, .master_reset_hiz_n_in, .hsel_in, .haddr_in, .htrans_in,
		.hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
		.external_feedback_in(peripheral_bus_clock_out[6]), .phase_detector_feedback_out,
		.double_rate_cpu_clock_out, .double_rate_cpu_clock_oe_n_out, .half_rate_cpu_clock_out,
		.half_rate_cpu_clock_oe_n_out, .bus_clock_qualifier_out, .bus_clock_qualifier_oe_n_out, .bus_clock_out,
		.bus_clock_oe_n_out, .peripheral_bus_clock_out, .peripheral_bus_clock_oe_n_out);
	for (genvar g = 0; g < 6; g++)
	begin : g_load
		pllodn_clock_load u_load (.clock_in, .tap_in(taps[g]), .period_out(per_q[g]), .high_out(hi_q[g]));
	end
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		hsel_in <= 1'b1;
		htrans_in <= 2'h2;
		haddr_in <= a;
		hwrite_in <= wr;
		do @(posedge clock_in); while (hreadyout_out !== 1'b1 && ++n < 50);
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= wd;
		do @(posedge clock_in); while (hreadyout_out !== 1'b1 && ++n < 50);
		rd = hrdata_out;
		if (n >= 50)
			num_errors++;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_defaults;
		bus(1'b0, `PLLODN_ADDR_CTRL, 32'h0000_0000);
		check("ctrl reset", rd, `PLLODN_CTRL_RESET);
		check("hresp", hresp_out, 32'h0000_0000);
		bus(1'b1, 32'h0000_0110, 32'h0000_0000);
		bus(1'b0, 32'h0000_0010, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		bus(1'b0, `PLLODN_ADDR_CTRL, 32'h0000_0000);
		check("ctrl after unmapped", rd, `PLLODN_CTRL_RESET);
		bus(1'b1, `PLLODN_ADDR_STAT, 32'h0000_0000);
		bus(1'b0, `PLLODN_ADDR_STAT, 32'h0000_0000);
		check("stat", rd[6:5], 2'h3);
	endtask
	task automatic t_ratios;
		int p, b, q, qh, pr;
		for (int i = 0; i < 64; i++)
		begin
			bus(1'b1, `PLLODN_ADDR_CTRL, 64 + i);
			repeat (260) @(posedge clock_in);
			p = i[4] ? 1 : 2;
			b = 4 * (i[1:0] + 1);
			q = i[5] ? b : 4;
			qh = (i[5] && i[1]) ? b - 4 : q / 2;
			pr = (i[3:2] == 3) ? 4 : b * (i[3:2] + 1);
			check("double", per_q[0], (i[5] ? 2 : 4) * p);
			check("double high", hi_q[0], (i[5] ? 1 : 2) * p);
			check("half", per_q[1], 4 * p);
			check("half high", hi_q[1], 2 * p);
			check("qual", per_q[2], q * p);
			check("qual high", hi_q[2], qh * p);
			check("bus", per_q[3], b * p);
			check("bus high", hi_q[3], b * p / 2);
			check("periph", per_q[4], pr * p);
			check("periph high", hi_q[4], pr * p / 2);
			check("feedback", per_q[5], 32);
		end
	endtask
	task automatic t_ext;
		bus(1'b1, `PLLODN_ADDR_CTRL, 32'h0000_0000);
		repeat (260) @(posedge clock_in);
		check("fed back", per_q[5], 8);
		check("periph", per_q[4], 8);
		bus(1'b1, `PLLODN_ADDR_CTRL, `PLLODN_CTRL_RESET);
	endtask
	task automatic t_mreset;
		master_reset_hiz_n_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		check("floated", {bus_clock_oe_n_out, peripheral_bus_clock_oe_n_out, half_rate_cpu_clock_oe_n_out,
			double_rate_cpu_clock_oe_n_out, bus_clock_qualifier_oe_n_out}, 32'h0000_7fff);
		check("stopped", {bus_clock_out, peripheral_bus_clock_out, half_rate_cpu_clock_out,
			double_rate_cpu_clock_out, bus_clock_qualifier_out}, 32'h0000_0000);
		bus(1'b0, `PLLODN_ADDR_CTRL, 32'h0000_0000);
		check("ctrl kept", rd, `PLLODN_CTRL_RESET);
		master_reset_hiz_n_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		check("driven", {bus_clock_oe_n_out, peripheral_bus_clock_oe_n_out}, 32'h0000_0000);
	endtask
	initial
	begin
		repeat (16) @(posedge clock_in);
		srst_in <= 1'b0;
		@(posedge clock_in);
		t_defaults;
		t_ratios;
		t_ext;
		t_mreset;
		print_verdict;
	end
	initial
	begin
		#1000000;
		num_errors++;
		print_verdict;
	end
endmodule
bind pllodn_divider_network pllodn_chk #(.BUS_COUNT(BUS_COUNT), .PER_COUNT(PER_COUNT)) u_chk (.clock_in,
	.srst_in, .master_reset_hiz_n_in, .hsel_in, .hwrite_in, .double_rate_cpu_clock_out, .half_rate_cpu_clock_out,
	.half_rate_cpu_clock_oe_n_out, .bus_clock_qualifier_out, .bus_clock_out, .peripheral_bus_clock_out,
	.peripheral_bus_clock_oe_n_out);
